// File: rtl/twm_pkg.sv
// package for the two-wire master transmitter: register map, fields, codes, timing
// Overview of operation
// R01 - enabled with start request and flag cleared, send START once bus is free
// R02 - software requests START with flag, start, enable one and stop zero in one write
// R03 - after START goes out, set done flag and status 0x08
// R04 - write bit selects transmit mode, read bit selects receive mode
// R05 - software loads address packet, then clears flag with start and stop zero
// R06 - after address and ack bit, report 0x18 ack, 0x20 nack, 0x38 lost
// R07 - software writes the data register only while the done flag is high
// R08 - data write with done flag low is dropped and sets write collision flag
// R09 - in 0x18..0x30, cleared flag with no start or stop sends loaded byte
// R10 - after data byte, set flag and report 0x28 ack or 0x30 nack
// R11 - software repeats byte sequence, then ends with STOP or repeated START
// R12 - flag cleared with stop only: send STOP, then clear stop request
// R13 - flag cleared with start and stop: send STOP then START, clear stop
// R14 - flag cleared with start only: repeated START, keep bus, report 0x10
// R15 - in 0x10, read address packet switches device into receive mode
// R16 - after 0x38, no start releases bus; start waits for free bus
// R17 - status codes assume prescaler bits zero; compare only upper five bits
// R18 - while done flag is set the bus transfer stays suspended
// R19 - software masks status with 0xF8 before comparing codes
// R20 - interrupt request raised while done flag and interrupt enable are set
package twm_pkg;
   // apb byte addresses
   localparam logic [7:0] TWM_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] TWM_ADDR_STATUS = 8'h04;
   localparam logic [7:0] TWM_ADDR_DATA   = 8'h08;
   localparam logic [7:0] TWM_ADDR_MODE   = 8'h0C;
   // control field positions
   localparam int TWM_CB_IE    = 0;
   localparam int TWM_CB_EN    = 2;
   localparam int TWM_CB_WC    = 3;
   localparam int TWM_CB_STO   = 4;
   localparam int TWM_CB_STA   = 5;
   localparam int TWM_CB_EA    = 6;
   localparam int TWM_CB_INT   = 7;
   localparam logic [7:0] TWM_STATUS_MASK = 8'hF8;
   localparam logic [7:0] TWM_CTRL_RST    = 8'h00;
   localparam logic [7:0] TWM_DATA_RST    = 8'hFF;
   // status codes, prescaler bits zero
   localparam logic [7:0] TWM_ST_START   = 8'h08;
   localparam logic [7:0] TWM_ST_RSTART  = 8'h10;
   localparam logic [7:0] TWM_ST_SLA_ACK = 8'h18;
   localparam logic [7:0] TWM_ST_SLA_NAK = 8'h20;
   localparam logic [7:0] TWM_ST_DAT_ACK = 8'h28;
   localparam logic [7:0] TWM_ST_DAT_NAK = 8'h30;
   localparam logic [7:0] TWM_ST_ARB     = 8'h38;
   localparam logic [7:0] TWM_ST_IDLE    = 8'hF8;
   // bus timing: quarter bit period
   localparam int TWM_CLK_HZ     = 20_000_000;
   localparam int TWM_QUARTER_NS = 2500;
   localparam int TWM_QUARTER_CY = (TWM_QUARTER_NS * (TWM_CLK_HZ / 1_000_000)) / 1000;
   // bus pins travel together
   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } twm_pins_t;
   typedef enum logic [1:0] {
      TWM_MODE_NONE,
      TWM_MODE_XMIT,
      TWM_MODE_RECV
   } twm_mode_t;
endpackage : twm_pkg

// File: rtl/twm_sync.sv
// three-stage synchroniser with agreement filter for one bus pin
`timescale 1ns/10ps
module twm_sync (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output logic      level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   // first stage feeds only the second; reset to released-bus level
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         level <= 1'b1;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            level <= s3_ff;
         end
      end
   end
endmodule : twm_sync

// File: rtl/twm_master.sv
// two-wire master transmitter with apb register access
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
module twm_master #(
   parameter int QUARTER_CY = twm_pkg::TWM_QUARTER_CY
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output twm_pkg::twm_pins_t pins,
   output logic             step_irq
);
   import twm_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_WAIT_FREE, S_START, S_BIT_LOW, S_BIT_HIGH, S_ACK_LOW, S_ACK_HIGH,
      S_STOP, S_HOLD
   } twm_state_t;

   twm_state_t state_ff;
   logic [7:0] ctrl_ff;
   logic [7:0] status_ff;
   logic [7:0] data_ff;
   twm_mode_t  mode_ff;
   logic [2:0] bit_ff;
   logic [1:0] phase_ff;
   logic [15:0] tick_ff;
   logic        own_ff;
   logic        addr_phase_ff;
   logic        restart_after_ff;
   logic        busy_ff;
   logic        scl_s;
   logic        sda_s;
   logic        sda_d_ff;
   logic        scl_d_ff;
   logic        wr_acc;
   logic        rd_acc;
   logic        kick;
   logic        tick;
   logic        flag_set;

   twm_sync u_sync_scl (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (scl_in),
      .level   (scl_s)
   );
   twm_sync u_sync_sda (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (sda_in),
      .level   (sda_s)
   );

   // apb strobes; slave answers in the access cycle, zero wait
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   // software clears the done flag by writing one to it
   assign kick = wr_acc && (paddr == TWM_ADDR_CTRL) && pwdata[TWM_CB_INT]
                 && pwdata[TWM_CB_EN];
   assign tick = (tick_ff == 16'(QUARTER_CY - 1));

   // quarter bit timer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_ff <= 16'h0000;
      end else if (tick || state_ff == S_HOLD || state_ff == S_IDLE) begin
         tick_ff <= 16'h0000;
      end else begin
         tick_ff <= tick_ff + 16'h0001;
      end
   end

   // bus busy tracking from start and stop seen on the wires
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_d_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         busy_ff  <= 1'b0;
      end else begin
         sda_d_ff <= sda_s;
         scl_d_ff <= scl_s;
         if (scl_s && scl_d_ff && sda_d_ff && !sda_s) begin
            busy_ff <= 1'b1;
         end else if (scl_s && scl_d_ff && !sda_d_ff && sda_s) begin
            busy_ff <= 1'b0;
         end
      end
   end

   assign flag_set = (state_ff == S_START && tick && phase_ff == 2'd1)
                  || (state_ff == S_ACK_HIGH && tick && phase_ff == 2'd1)
                  || (state_ff == S_BIT_HIGH && tick && phase_ff == 2'd1 && own_ff
                      && (sda_s != data_ff[bit_ff]));

   // control register: flag set by hardware wins over a software clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= TWM_CTRL_RST;
      end else begin
         if (wr_acc && paddr == TWM_ADDR_CTRL) begin
            ctrl_ff[TWM_CB_IE]  <= pwdata[TWM_CB_IE];
            ctrl_ff[TWM_CB_EN]  <= pwdata[TWM_CB_EN];
            ctrl_ff[TWM_CB_STA] <= pwdata[TWM_CB_STA];
            ctrl_ff[TWM_CB_STO] <= pwdata[TWM_CB_STO];
            ctrl_ff[TWM_CB_EA]  <= pwdata[TWM_CB_EA];
            if (pwdata[TWM_CB_INT]) begin
               ctrl_ff[TWM_CB_INT] <= 1'b0;
               ctrl_ff[TWM_CB_WC]  <= 1'b0;
            end
         end
         if (wr_acc && paddr == TWM_ADDR_DATA && !ctrl_ff[TWM_CB_INT]) begin
            ctrl_ff[TWM_CB_WC] <= 1'b1; // R08
         end
         if (flag_set) begin
            ctrl_ff[TWM_CB_INT] <= 1'b1; // R03
         end
         if (state_ff == S_STOP && tick && phase_ff == 2'd2) begin
            ctrl_ff[TWM_CB_STO] <= 1'b0; // R12 R13
         end
         if (state_ff == S_START && tick && phase_ff == 2'd1) begin
            ctrl_ff[TWM_CB_STA] <= 1'b0;
         end
      end
   end

   // data register only accepts writes while the flag is up
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_ff <= TWM_DATA_RST;
      end else if (wr_acc && paddr == TWM_ADDR_DATA && ctrl_ff[TWM_CB_INT]) begin
         data_ff <= pwdata[7:0]; // R08
      end
   end

   // main bus sequencer; holds in S_HOLD until flag cleared with enable set
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff         <= S_IDLE;
         status_ff        <= TWM_ST_IDLE;
         mode_ff          <= TWM_MODE_NONE;
         bit_ff           <= 3'd7;
         phase_ff         <= 2'd0;
         own_ff           <= 1'b0;
         addr_phase_ff    <= 1'b0;
         restart_after_ff <= 1'b0;
         pins             <= '0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               pins <= '0;
               if (kick && pwdata[TWM_CB_STA] && !pwdata[TWM_CB_STO]) begin
                  state_ff <= S_WAIT_FREE; // R01
               end
            end
            S_WAIT_FREE: begin
               // start only once nobody else holds the bus
               if (!busy_ff && scl_s && sda_s) begin // R01 R16
                  state_ff <= S_START;
                  phase_ff <= 2'd0;
               end
            end
            S_START: begin
               // phase 0 raise both, phase 1 pull sda low with scl high
               if (tick) begin
                  if (phase_ff == 2'd0) begin
                     pins.scl_oe <= 1'b0;
                     pins.sda_oe <= 1'b0;
                     phase_ff    <= 2'd1;
                  end else begin
                     pins.sda_oe   <= 1'b1;
                     status_ff     <= own_ff ? TWM_ST_RSTART : TWM_ST_START; // R03 R14
                     own_ff        <= 1'b1;
                     addr_phase_ff <= 1'b1;
                     state_ff      <= S_HOLD;
                  end
               end
            end
            S_HOLD: begin
               pins.scl_oe <= 1'b1; // R18
               if (kick) begin
                  phase_ff <= 2'd0;
                  bit_ff   <= 3'd7;
                  if (status_ff == TWM_ST_ARB) begin
                     own_ff   <= 1'b0;
                     pins     <= '0;
                     state_ff <= pwdata[TWM_CB_STA] ? S_WAIT_FREE : S_IDLE; // R16
                  end else if (pwdata[TWM_CB_STO]) begin
                     restart_after_ff <= pwdata[TWM_CB_STA]; // R13
                     state_ff         <= S_STOP; // R12
                  end else if (pwdata[TWM_CB_STA]) begin
                     state_ff <= S_START; // R14
                  end else begin
                     state_ff <= S_BIT_LOW; // R09
                  end
               end
            end
            S_BIT_LOW: begin
               if (tick) begin
                  if (phase_ff == 2'd0) begin
                     pins.sda_oe <= !data_ff[bit_ff];
                     phase_ff    <= 2'd1;
                  end else begin
                     pins.scl_oe <= 1'b0;
                     phase_ff    <= 2'd0;
                     state_ff    <= S_BIT_HIGH;
                  end
               end
            end
            S_BIT_HIGH: begin
               if (tick) begin
                  if (phase_ff == 2'd0) begin
                     phase_ff <= 2'd1;
                  end else if (sda_s != data_ff[bit_ff]) begin
                     // lost arbitration: let go of sda, report and hold
                     pins.sda_oe <= 1'b0;
                     status_ff   <= TWM_ST_ARB; // R06
                     state_ff    <= S_HOLD;
                  end else begin
                     pins.scl_oe <= 1'b1;
                     phase_ff    <= 2'd0;
                     if (bit_ff == 3'd0) begin
                        state_ff <= S_ACK_LOW;
                     end else begin
                        bit_ff   <= bit_ff - 3'd1;
                        state_ff <= S_BIT_LOW;
                     end
                  end
               end
            end
            S_ACK_LOW: begin
               if (tick) begin
                  pins.sda_oe <= 1'b0;
                  if (phase_ff == 2'd1) begin
                     pins.scl_oe <= 1'b0;
                     phase_ff    <= 2'd0;
                     state_ff    <= S_ACK_HIGH;
                  end else begin
                     phase_ff <= 2'd1;
                  end
               end
            end
            S_ACK_HIGH: begin
               if (tick) begin
                  if (phase_ff == 2'd0) begin
                     phase_ff <= 2'd1;
                  end else begin
                     state_ff      <= S_HOLD;
                     addr_phase_ff <= 1'b0;
                     if (addr_phase_ff) begin
                        mode_ff   <= data_ff[0] ? TWM_MODE_RECV : TWM_MODE_XMIT; // R04 R15
                        status_ff <= sda_s ? TWM_ST_SLA_NAK : TWM_ST_SLA_ACK; // R06
                     end else begin
                        status_ff <= sda_s ? TWM_ST_DAT_NAK : TWM_ST_DAT_ACK; // R10
                     end
                  end
               end
            end
            S_STOP: begin
               // sda low first, then release scl, then release sda with scl high;
               // moving sda and scl in one step could read as a start far side
               if (tick) begin
                  if (phase_ff == 2'd0) begin
                     pins.sda_oe <= 1'b1;
                     phase_ff    <= 2'd1;
                  end else if (phase_ff == 2'd1) begin
                     pins.scl_oe <= 1'b0;
                     phase_ff    <= 2'd2;
                  end else begin
                     pins.sda_oe <= 1'b0;
                     own_ff      <= 1'b0;
                     mode_ff     <= TWM_MODE_NONE;
                     status_ff   <= TWM_ST_IDLE;
                     phase_ff    <= 2'd0;
                     state_ff    <= restart_after_ff ? S_WAIT_FREE : S_IDLE; // R13
                  end
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // apb read data, registered; prescaler bits read zero (R17)
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && paddr > TWM_ADDR_MODE;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               TWM_ADDR_CTRL:   prdata[7:0] <= ctrl_ff;
               TWM_ADDR_STATUS: prdata[7:0] <= status_ff & TWM_STATUS_MASK; // R17
               TWM_ADDR_DATA:   prdata[7:0] <= data_ff;
               TWM_ADDR_MODE:   prdata[1:0] <= mode_ff;
               default:         prdata      <= 32'h0000_0000;
            endcase
         end
      end
   end

   // interrupt request follows the flag while enabled
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         step_irq <= 1'b0;
      end else begin
         step_irq <= ctrl_ff[TWM_CB_INT] && ctrl_ff[TWM_CB_IE]; // R20
      end
   end

   AST_START_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_START && tick && phase_ff == 2'd1 && !own_ff)
      |=> (status_ff == TWM_ST_START && ctrl_ff[TWM_CB_INT]))  // R03
      else $error("start did not report 0x08");
   AST_HOLD_SUSPENDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_HOLD && !kick) |=> (state_ff == S_HOLD))  // R18
      else $error("transfer moved while flag set");
   AST_COLLISION: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_acc && paddr == TWM_ADDR_DATA && !ctrl_ff[TWM_CB_INT])
      |=> (ctrl_ff[TWM_CB_WC] && $stable(data_ff)))  // R08
      else $error("data write collision not handled");
   AST_STOP_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_STOP && tick && phase_ff == 2'd2) |=> !ctrl_ff[TWM_CB_STO])  // R12
      else $error("stop request not cleared");
   AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctrl_ff[TWM_CB_INT] && ctrl_ff[TWM_CB_IE]) |=> step_irq)  // R20
      else $error("interrupt missing");
   AST_DATA_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_ACK_HIGH && tick && phase_ff == 2'd1 && !addr_phase_ff)
      |=> (status_ff == TWM_ST_DAT_ACK || status_ff == TWM_ST_DAT_NAK))  // R10
      else $error("data status wrong");
   AST_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_ACK_HIGH && tick && phase_ff == 2'd1 && addr_phase_ff)
      |=> (mode_ff == (data_ff[0] ? TWM_MODE_RECV : TWM_MODE_XMIT)))  // R04
      else $error("mode not selected");
   AST_SEND_BYTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_ff == S_HOLD && kick && status_ff != TWM_ST_ARB
       && !pwdata[TWM_CB_STA] && !pwdata[TWM_CB_STO]) |=> (state_ff == S_BIT_LOW))  // R09
      else $error("byte not started");
endmodule : twm_master

// File: tb/twm_slave_model.sv
// slave receiver model on the two-wire bus: ack, byte capture, arbitration grab
`timescale 1ns/10ps
module twm_slave_model (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack,
   input  wire logic       grab,
   output logic            sda_oe,
   output logic [7:0]      rx_byte,
   output logic [7:0]      starts,
   output logic [7:0]      stops
);
   logic       scl_ff;
   logic       sda_ff;
   logic       frame_ff;
   logic       ack_ff;
   logic [3:0] bit_ff;
   logic [7:0] shift_ff;
   // bus events found by sampling both wires at the system clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_ff, sda_ff, frame_ff, ack_ff} <= 4'b1100;
         bit_ff <= 4'h0;
         shift_ff <= 8'h00;
         rx_byte <= 8'h00;
         starts <= 8'h00;
         stops <= 8'h00;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
         if (scl && scl_ff && sda_ff && !sda) begin
            // start and repeated start both restart the bit count
            frame_ff <= 1'b1;
            bit_ff <= 4'h0;
            ack_ff <= 1'b0;
            starts <= starts + 8'h01;
         end else if (scl && scl_ff && !sda_ff && sda) begin
            frame_ff <= 1'b0;
            ack_ff <= 1'b0;
            stops <= stops + 8'h01;
         end else if (frame_ff && scl && !scl_ff) begin
            if (bit_ff < 4'h8) shift_ff <= {shift_ff[6:0], sda};
            if (bit_ff == 4'h7) rx_byte <= {shift_ff[6:0], sda};
            bit_ff <= bit_ff + 4'h1;
         end else if (frame_ff && !scl && scl_ff) begin
            // ack held across the whole ninth clock, low to low
            if (bit_ff == 4'h8) ack_ff <= 1'b1;
            else if (bit_ff == 4'h9) begin
               ack_ff <= 1'b0;
               bit_ff <= 4'h0;
            end
         end
      end
   end
   // grab pulls the first address bit low to win arbitration; held until the next scl rise after the first bit
   assign sda_oe = (ack_ff & ~nack) | (grab & frame_ff & (bit_ff <= 4'h1));
endmodule : twm_slave_model

// File: tb/twm_master_test.sv
// testbench for the two-wire master transmitter driven over apb
`timescale 1ns/10ps
module twm_master_test;
   import twm_pkg::*;
   logic        sys_clk, rst_n, psel, penable, pwrite, nack, grab, slv_oe;
   logic [7:0]  paddr, rx_byte, starts, stops, s0;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, step_irq, err;
   twm_pins_t   pins;
   int          bad_count, checks_done;
   // open-drain wires with pull-ups
   wire scl = ~pins.scl_oe;
   wire sda = ~(pins.sda_oe | slv_oe);

   twm_master #(.QUARTER_CY(2)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .pins(pins),
      .step_irq(step_irq));
   twm_slave_model i_slave (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda(sda),
      .nack(nack), .grab(grab), .sda_oe(slv_oe), .rx_byte(rx_byte), .starts(starts),
      .stops(stops));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; the request stands until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk({24'h00_0000, rd[7:0]}, {24'h00_0000, e});
   endtask : rchk

   // poll one control bit, bounded
   task automatic wait_bit(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, TWM_ADDR_CTRL, 8'h00);
         n++;
      end while (rd[b] !== v && n < 400);
      if (n >= 400) bad_count++;
   endtask : wait_bit

   // control write, wait for the done flag, compare masked status
   task automatic step(input logic [7:0] c, input logic [7:0] st);
      apb(1'b1, TWM_ADDR_CTRL, c);
      wait_bit(TWM_CB_INT, 1'b1);
      apb(1'b0, TWM_ADDR_STATUS, 8'h00);
      chk({24'h00_0000, rd[7:0] & TWM_STATUS_MASK}, {24'h00_0000, st});
   endtask : step

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // watchdog far beyond the thousand or so cycles the tests need
   initial begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      close_out();
   end

   initial begin
      {rst_n, psel, penable, pwrite, nack, grab} = 6'b00_0000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      bad_count = 0;
      checks_done = 0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(TWM_ADDR_CTRL, TWM_CTRL_RST);
      rchk(TWM_ADDR_STATUS, TWM_ST_IDLE);
      rchk(TWM_ADDR_DATA, TWM_DATA_RST);
      apb(1'b0, 8'h10, 8'h00);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b1, TWM_ADDR_DATA, 8'h3C);
      rchk(TWM_ADDR_DATA, TWM_DATA_RST);
      rchk(TWM_ADDR_CTRL, 8'h08);
      $display("test registers done");
      step(8'hA5, TWM_ST_START);
      chk({31'h0, step_irq}, 32'h0000_0001);
      apb(1'b1, TWM_ADDR_DATA, 8'hA0);
      // a loaded byte must not move while the flag stays set
      repeat (200) @(posedge sys_clk);
      chk({24'h00_0000, rx_byte}, 32'h0000_0000);
      step(8'h84, TWM_ST_SLA_ACK);
      chk({31'h0, step_irq}, 32'h0000_0000);
      chk({24'h00_0000, rx_byte}, 32'h0000_00A0);
      rchk(TWM_ADDR_MODE, 8'(TWM_MODE_XMIT));
      $display("test address done");
      apb(1'b1, TWM_ADDR_DATA, 8'h5A);
      step(8'h84, TWM_ST_DAT_ACK);
      chk({24'h00_0000, rx_byte}, 32'h0000_005A);
      nack <= 1'b1;
      apb(1'b1, TWM_ADDR_DATA, 8'hC3);
      step(8'h84, TWM_ST_DAT_NAK);
      nack <= 1'b0;
      apb(1'b1, TWM_ADDR_DATA, 8'h96);
      step(8'h84, TWM_ST_DAT_ACK);
      chk({24'h00_0000, rx_byte}, 32'h0000_0096);
      $display("test data done");
      step(8'hB4, TWM_ST_START);
      chk({24'h00_0000, stops}, 32'h0000_0001);
      chk({24'h00_0000, starts}, 32'h0000_0002);
      apb(1'b0, TWM_ADDR_CTRL, 8'h00);
      chk({31'h0, rd[TWM_CB_STO]}, 32'h0000_0000);
      nack <= 1'b1;
      apb(1'b1, TWM_ADDR_DATA, 8'hA0);
      step(8'h84, TWM_ST_SLA_NAK);
      nack <= 1'b0;
      apb(1'b1, TWM_ADDR_CTRL, 8'h94);
      wait_bit(TWM_CB_STO, 1'b0);
      chk({24'h00_0000, stops}, 32'h0000_0002);
      $display("test stop done");
      step(8'hA4, TWM_ST_START);
      grab <= 1'b1;
      apb(1'b1, TWM_ADDR_DATA, 8'hA0);
      step(8'h84, TWM_ST_ARB);
      apb(1'b1, TWM_ADDR_CTRL, 8'h84);
      // bus release has no completion flag; allow a few bit times. the grabbing side
      // lets sda go once scl rises: that is the winner's stop, which frees the bus
      repeat (64) @(posedge sys_clk);
      grab <= 1'b0;
      chk({30'h0, pins}, 32'h0000_0000);
      chk({24'h00_0000, stops}, 32'h0000_0003);
      rchk(TWM_ADDR_MODE, 8'(TWM_MODE_NONE));
      $display("test arbitration done");
      step(8'hA4, TWM_ST_START);
      apb(1'b1, TWM_ADDR_DATA, 8'hA0);
      step(8'h84, TWM_ST_SLA_ACK);
      s0 = stops;
      step(8'hA4, TWM_ST_RSTART);
      chk({24'h00_0000, stops}, {24'h00_0000, s0});
      apb(1'b1, TWM_ADDR_DATA, 8'hA1);
      apb(1'b1, TWM_ADDR_CTRL, 8'h84);
      wait_bit(TWM_CB_INT, 1'b1);
      chk({24'h00_0000, rx_byte}, 32'h0000_00A1);
      rchk(TWM_ADDR_MODE, 8'(TWM_MODE_RECV));
      $display("test repeated start done");
      close_out();
   end
endmodule : twm_master_test
